// ---- core/rhpcf_delay.sv ----
/*
 * Retriggerable one-shot delay counter.
 * Assumes start is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/1ps
module rhpcf_delay #(
    parameter int unsigned CYCLES = 150000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    output logic done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q;
    logic busy_q;

    // =========================================
    // counter: done pulses when the count runs out
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= CW'(CYCLES - 1);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q == '0) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule // rhpcf_delay

// ---- core/rhpcf_top.sv ----
/*
 * Change flags of one root-hub port, with Avalon-MM register access
 * and a level interrupt.
 * Assumes the port state machine drives the live status inputs and the
 * resume/eop strobes from the same CORE_CLK domain.
 */
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
// Contract
// RL1: reset change flag cleared by writing one
// RL2: reset status change sets reset change flag
// RL3: overcurrent change flag always reads zero
// RL4: suspend change flag cleared by writing one
// RL5: suspend flag sets after resume, eop, 3ms
// RL6: enable change flag cleared by writing one
// RL7: enable status change sets enable flag
// RL8: connect flag; nonremovable sets after hub reset
// RL9: request while disconnected sets connect flag; not done here while nonremovable is set
// RL10: flags reset zero, zero writes harmless
// RL11: set beats clear in same cycle
`timescale 1ns/1ps
module rhpcf_top
    import rhpcf_pkg::*;
#(
    parameter int unsigned SYNC_CYCLES = rhpcf_pkg::SYNC_DELAY_CYC
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic [1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic PORT_CONNECT,
    input wire logic PORT_ENABLE,
    input wire logic PORT_SUSPEND,
    input wire logic PORT_RESET,
    input wire logic RESUME_EOP_DONE,
    input wire logic HUB_RESET_DONE,
    output logic SET_PORT_RESET,
    output logic SET_PORT_ENABLE,
    output logic SET_PORT_SUSPEND,
    output logic IRQ
);
    // =========================================
    // local signals
    logic connect_chg_q, enable_chg_q, suspend_chg_q, reset_chg_q;
    logic prev_connect_q, prev_enable_q, prev_reset_q;
    logic [EVT_W-1:0] irq_sts_q;
    logic [EVT_W-1:0] irq_mask_q;
    logic nonremovable_q;
    logic ack_q;
    logic wr_take, rd_take, status_wr;
    logic clr_conn, clr_en, clr_susp, clr_rst;
    logic set_conn, set_en, set_susp, set_rst;
    logic req_while_off;
    logic sync_done;
    logic [EVT_W-1:0] evt_vec;

    // =========================================
    // avalon handshake: one wait cycle, answer on the second edge
    // a registered ack keeps readdata from a flip-flop at the sample edge
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
    assign wr_take = AVS_WRITE & ack_q;
    assign rd_take = AVS_READ & ack_q;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
        end
    end

    // write one to clear, write zero leaves the flag alone
    // every input is an argument: a continuous assign only re-evaluates
    // when its operands change, not when a signal read inside does
    function automatic logic w1c(input logic wr, input logic [3:0] be,
            input logic [31:0] wd, input int unsigned pos);
        return wr & be[pos/8] & wd[pos];
    endfunction

    assign status_wr = wr_take & (AVS_ADDRESS == OFS_PORT_STATUS);
    assign clr_rst = w1c(status_wr, AVS_BYTEENABLE, AVS_WRITEDATA,
        BIT_RESET_CHG); // [RL1]
    assign clr_susp = w1c(status_wr, AVS_BYTEENABLE, AVS_WRITEDATA,
        BIT_SUSPEND_CHG); // [RL4]
    assign clr_en = w1c(status_wr, AVS_BYTEENABLE, AVS_WRITEDATA,
        BIT_ENABLE_CHG); // [RL6]
    assign clr_conn = w1c(status_wr, AVS_BYTEENABLE, AVS_WRITEDATA,
        BIT_CONNECT_CHG); // [RL8]

    // =========================================
    // set requests for port reset, enable, suspend
    // these strobe the external port machine; low bits are write-one
    assign SET_PORT_RESET = status_wr & AVS_BYTEENABLE[0]
        & AVS_WRITEDATA[BIT_RESET_STS];
    assign SET_PORT_ENABLE = status_wr & AVS_BYTEENABLE[0]
        & AVS_WRITEDATA[BIT_ENABLE_STS];
    assign SET_PORT_SUSPEND = status_wr & AVS_BYTEENABLE[0]
        & AVS_WRITEDATA[BIT_SUSPEND_STS];
    assign req_while_off = (SET_PORT_RESET | SET_PORT_ENABLE
        | SET_PORT_SUSPEND) & ~PORT_CONNECT; // [RL9]

    // =========================================
    // previous status for edge detection
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            prev_connect_q <= 1'b0;
            prev_enable_q <= 1'b0;
            prev_reset_q <= 1'b0;
        end else begin
            prev_connect_q <= PORT_CONNECT;
            prev_enable_q <= PORT_ENABLE;
            prev_reset_q <= PORT_RESET;
        end
    end

    // =========================================
    // resume sync delay: starts only after resume pulse and eop finish
    rhpcf_delay #(
        .CYCLES(SYNC_CYCLES)
    ) u_sync_delay (
        .clk(CORE_CLK),
        .nrst(NRST),
        .start(RESUME_EOP_DONE),
        .done(sync_done)
    );

    // =========================================
    // hardware set conditions
    assign set_rst = PORT_RESET ^ prev_reset_q; // [RL2]
    assign set_en = PORT_ENABLE ^ prev_enable_q; // [RL7]
    assign set_susp = sync_done; // [RL5]
    // a non-removable device reports attach only after a hub reset
    assign set_conn = nonremovable_q ? HUB_RESET_DONE
        : ((PORT_CONNECT ^ prev_connect_q) | req_while_off); // [RL8] [RL9]

    // =========================================
    // sticky change flags, set wins over clear
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            reset_chg_q <= 1'b0; // [RL10]
            suspend_chg_q <= 1'b0;
            enable_chg_q <= 1'b0;
            connect_chg_q <= 1'b0;
        end else begin
            reset_chg_q <= set_rst | (reset_chg_q & ~clr_rst); // [RL11]
            suspend_chg_q <= set_susp | (suspend_chg_q & ~clr_susp);
            enable_chg_q <= set_en | (enable_chg_q & ~clr_en);
            connect_chg_q <= set_conn | (connect_chg_q & ~clr_conn);
        end
    end

    // =========================================
    // interrupt status: sticky, cleared by reading it, set wins
    assign evt_vec = {set_rst, 1'b0, set_susp, set_en, set_conn};

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_sts_q <= FLAGS_RST;
        end else if (rd_take && AVS_ADDRESS == OFS_IRQ_STATUS) begin
            irq_sts_q <= evt_vec;
        end else begin
            irq_sts_q <= irq_sts_q | evt_vec;
        end
    end

    // =========================================
    // mask and configuration registers
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_mask_q <= MASK_RST;
            nonremovable_q <= NONREM_RST;
        end else if (wr_take && AVS_BYTEENABLE[0]) begin
            if (AVS_ADDRESS == OFS_IRQ_MASK) begin
                irq_mask_q <= AVS_WRITEDATA[EVT_W-1:0];
            end
            if (AVS_ADDRESS == OFS_PORT_CONFIG) begin
                nonremovable_q <= AVS_WRITEDATA[BIT_NONREMOVABLE];
            end
        end
    end

    // level interrupt while any unmasked status bit is set
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_sts_q & irq_mask_q);
        end
    end

    // =========================================
    // read data, registered; unmapped bits and overcurrent read zero
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            AVS_READDATA <= 32'h00000000;
        end else if (AVS_READ && !ack_q) begin
            AVS_READDATA <= 32'h00000000;
            unique case (AVS_ADDRESS)
                OFS_PORT_STATUS: begin
                    AVS_READDATA[BIT_RESET_CHG] <= reset_chg_q;
                    AVS_READDATA[BIT_OVERCURRENT_CHG] <= 1'b0; // [RL3]
                    AVS_READDATA[BIT_SUSPEND_CHG] <= suspend_chg_q;
                    AVS_READDATA[BIT_ENABLE_CHG] <= enable_chg_q;
                    AVS_READDATA[BIT_CONNECT_CHG] <= connect_chg_q;
                    AVS_READDATA[BIT_RESET_STS] <= PORT_RESET;
                    AVS_READDATA[BIT_SUSPEND_STS] <= PORT_SUSPEND;
                    AVS_READDATA[BIT_ENABLE_STS] <= PORT_ENABLE;
                    AVS_READDATA[BIT_CONNECT_STS] <= PORT_CONNECT;
                end
                OFS_IRQ_STATUS: begin
                    // include this cycle's events: the clear edge drops them
                    AVS_READDATA[EVT_W-1:0] <= irq_sts_q | evt_vec;
                end
                OFS_IRQ_MASK: begin
                    AVS_READDATA[EVT_W-1:0] <= irq_mask_q;
                end
                OFS_PORT_CONFIG: begin
                    AVS_READDATA[BIT_NONREMOVABLE] <= nonremovable_q;
                end
            endcase
        end
    end
endmodule // rhpcf_top

// ---- shared/rhpcf_pkg.sv ----
/*
 * Constants for the root-hub port change flag block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 50 MHz core clock and a word-addressed Avalon-MM slave.
 */
package rhpcf_pkg;
    // clock rate
    localparam int unsigned CLK_HZ = 50000000;
    // register word offsets (byte address = 4 * index)
    localparam logic [1:0] OFS_PORT_STATUS = 2'h0;
    localparam logic [1:0] OFS_IRQ_STATUS = 2'h1;
    localparam logic [1:0] OFS_IRQ_MASK = 2'h2;
    localparam logic [1:0] OFS_PORT_CONFIG = 2'h3;
    // change flag positions in the port status word
    localparam int unsigned BIT_CONNECT_CHG = 16;
    localparam int unsigned BIT_ENABLE_CHG = 17;
    localparam int unsigned BIT_SUSPEND_CHG = 18;
    localparam int unsigned BIT_OVERCURRENT_CHG = 19;
    localparam int unsigned BIT_RESET_CHG = 20;
    // live status positions in the port status word
    localparam int unsigned BIT_CONNECT_STS = 0;
    localparam int unsigned BIT_ENABLE_STS = 1;
    localparam int unsigned BIT_SUSPEND_STS = 2;
    localparam int unsigned BIT_RESET_STS = 4;
    // configuration bit: port holds a non-removable device
    localparam int unsigned BIT_NONREMOVABLE = 0;
    // event positions in interrupt status / mask (five change flags)
    localparam int unsigned EVT_W = 5;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam logic NONREM_RST = 1'b0;
    // resume synchronization delay
    localparam int unsigned SYNC_DELAY_MS = 3;
    localparam int unsigned SYNC_DELAY_CYC = SYNC_DELAY_MS * (CLK_HZ / 1000);
endpackage

// ---- test/rhpcf_port_model.sv ----
/* stand-in for the port state machine and attached device.
   assumes tasks are called just after a clock edge. */
`timescale 1ns/1ps
module rhpcf_port_model (
    input wire logic clk,
    output logic [3:0] lv,
    output logic [1:0] ev
);
    // ==========
    // levels {reset, suspend, enable, connect}; strobes {hub, resume}
    initial begin
        lv = 4'h0;
        ev = 2'h0;
    end
    // hold two edges so the flags have settled
    task automatic set_lv(input logic [3:0] v);
        lv <= v;
        repeat (2) @(posedge clk);
    endtask
    // one-cycle strobe
    task automatic pulse(input logic [1:0] k);
        ev <= k;
        @(posedge clk);
        ev <= 2'h0;
        @(posedge clk);
    endtask
endmodule // rhpcf_port_model

// ---- test/rhpcf_top_chk.sv ----
/* port checker for rhpcf_top, bound at the foot.
   assumes one clock domain and the bench's 1F/04/00 masks. */
`timescale 1ns/1ps
module rhpcf_chk #(
    parameter int unsigned SYNC_CYCLES = 20
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic [1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic PORT_ENABLE,
    input wire logic PORT_RESET,
    input wire logic RESUME_EOP_DONE,
    input wire logic SET_PORT_RESET,
    input wire logic SET_PORT_ENABLE,
    input wire logic SET_PORT_SUSPEND,
    input wire logic IRQ
);
    // ==========
    // helpers
    logic rq;
    logic wr_ok;
    logic rd_ok;
    logic [4:0] mask_q;
    assign rq = AVS_READ | AVS_WRITE;
    assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
    assign rd_ok = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 2'h0;
    // mask copy, since the checker cannot read it back
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            mask_q <= 5'h00;
        end else if (wr_ok && AVS_ADDRESS == 2'h2) begin
            mask_q <= AVS_WRITEDATA[4:0];
        end
    end
    // ==========
    // properties
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    property p_first; $rose(rq) |-> AVS_WAITREQUEST; endproperty
    a_first: assert property (p_first) else $error("no wait state");
    property p_one; rq && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
    a_one: assert property (p_one) else $error("wait too long");
    property p_idle; !rq |-> !AVS_WAITREQUEST; endproperty
    a_idle: assert property (p_idle) else $error("wait while idle");
    property p_oc; rd_ok |-> !AVS_READDATA[19]; endproperty
    a_oc: assert property (p_oc) else $error("oc flag set");
    property p_set; wr_ok && AVS_ADDRESS == 2'h0 && AVS_BYTEENABLE[0] |->
        {SET_PORT_RESET, SET_PORT_SUSPEND, SET_PORT_ENABLE}
        == {AVS_WRITEDATA[4], AVS_WRITEDATA[2:1]}; endproperty
    a_set: assert property (p_set) else $error("bad set pulse");
    property p_rst; $changed(PORT_RESET) && mask_q[4] |-> ##[1:3] IRQ;
    endproperty
    a_rst: assert property (p_rst) else $error("no reset irq");
    property p_en; $changed(PORT_ENABLE) && mask_q[1] |-> ##[1:3] IRQ;
    endproperty
    a_en: assert property (p_en) else $error("no enable irq");
    property p_sus; RESUME_EOP_DONE && !IRQ && mask_q == 5'h04
        |=> !IRQ [*8]; endproperty
    a_sus: assert property (p_sus) else $error("early suspend");
    c_rd: cover property (rd_ok);
    c_set: cover property (SET_PORT_RESET);
    c_irq: cover property ($rose(IRQ));
endmodule // rhpcf_chk
bind rhpcf_top rhpcf_chk #(.SYNC_CYCLES(SYNC_CYCLES)) rhpcf_chk_inst (
    .CORE_CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .PORT_ENABLE,
    .PORT_RESET, .RESUME_EOP_DONE, .SET_PORT_RESET, .SET_PORT_ENABLE,
    .SET_PORT_SUSPEND, .IRQ
);

// ---- test/root_hub_port_change_flags_test.sv ----
/* self-checking bench for rhpcf_top over Avalon-MM.
   assumes the sync delay shortened to 20 cycles. */
`timescale 1ns/1ps
module root_hub_port_change_flags_test;
    import rhpcf_pkg::*;
    logic CORE_CLK = 1'b0;
    logic NRST = 1'b0;
    logic [1:0] AVS_ADDRESS = 2'h0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, IRQ;
    wire PORT_CONNECT, PORT_ENABLE, PORT_SUSPEND, PORT_RESET;
    wire RESUME_EOP_DONE, HUB_RESET_DONE;
    wire SET_PORT_RESET, SET_PORT_ENABLE, SET_PORT_SUSPEND;
    logic [2:0] set_seen = 3'h0;
    int n_fail = 0;
    int n_checks = 0;
    int bs[3] = '{1, 2, 4};
    // ==========
    // clock and instances
    always #10 CORE_CLK = ~CORE_CLK;
    rhpcf_top #(.SYNC_CYCLES(20)) rhpcf_top_inst (
        .CORE_CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
        .AVS_WAITREQUEST, .PORT_CONNECT, .PORT_ENABLE, .PORT_SUSPEND,
        .PORT_RESET, .RESUME_EOP_DONE, .HUB_RESET_DONE,
        .SET_PORT_RESET, .SET_PORT_ENABLE, .SET_PORT_SUSPEND, .IRQ
    );
    rhpcf_port_model rhpcf_port_model_inst (.clk(CORE_CLK),
        .lv({PORT_RESET, PORT_SUSPEND, PORT_ENABLE, PORT_CONNECT}),
        .ev({HUB_RESET_DONE, RESUME_EOP_DONE}));
    // sticky record of request strobes; they stand for one cycle only
    always @(posedge CORE_CLK) begin
        set_seen <= set_seen
            | {SET_PORT_RESET, SET_PORT_SUSPEND, SET_PORT_ENABLE};
    end
    // ==========
    // tasks
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s exp %h seen %h", nm, e, s);
        end
    endtask
    // one access; waitrequest, write effect and read data at one edge
    task automatic bus(logic w, logic [1:0] a, logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        if (AVS_WAITREQUEST !== 1'b0) begin
            n_fail++;
            report_and_stop();
        end
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        // idle edge so the next call never re-raises in this time step
        @(posedge CORE_CLK);
    endtask
    task automatic rd(logic [1:0] a, logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk("readdata", q, e);
    endtask
    task automatic wr(logic [1:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    // ==========
    // main sequence
    initial begin
        repeat (3) @(posedge CORE_CLK);
        NRST <= 1'b1;
        @(posedge CORE_CLK);
        rd(OFS_PORT_STATUS, 32'h0);
        wr(OFS_IRQ_MASK, 32'h1F);
        rhpcf_port_model_inst.set_lv(4'hB);
        rd(OFS_PORT_STATUS, 32'h0013_0013);
        chk("irq", {31'h0, IRQ}, 32'h1);
        wr(OFS_PORT_STATUS, 32'h0);
        rd(OFS_PORT_STATUS, 32'h0013_0013);
        wr(OFS_PORT_STATUS, 32'h0010_0000);
        rd(OFS_PORT_STATUS, 32'h0003_0013);
        wr(OFS_PORT_STATUS, 32'h0002_0000);
        rd(OFS_PORT_STATUS, 32'h0001_0013);
        rd(OFS_IRQ_STATUS, 32'h13);
        rd(OFS_IRQ_STATUS, 32'h0);
        chk("irq", {31'h0, IRQ}, 32'h0);
        // suspend flag waits out the sync delay
        wr(OFS_IRQ_MASK, 32'h4);
        rhpcf_port_model_inst.pulse(2'h1);
        rd(OFS_PORT_STATUS, 32'h0001_0013);
        repeat (25) @(posedge CORE_CLK);
        rd(OFS_PORT_STATUS, 32'h0005_0013);
        // clear bit written with its byte lane off changes nothing
        AVS_BYTEENABLE <= 4'hB;
        wr(OFS_PORT_STATUS, 32'h0004_0000);
        rd(OFS_PORT_STATUS, 32'h0005_0013);
        AVS_BYTEENABLE <= 4'hF;
        wr(OFS_PORT_STATUS, 32'h0004_0000);
        rd(OFS_PORT_STATUS, 32'h0001_0013);
        // requests while disconnected, set against clear in one write
        rhpcf_port_model_inst.set_lv(4'hA);
        chk("set_pulse", {29'h0, set_seen}, 32'h0);
        foreach (bs[i]) begin
            wr(OFS_PORT_STATUS, 32'h0001_0000);
            rd(OFS_PORT_STATUS, 32'h0000_0012);
            wr(OFS_PORT_STATUS, 32'h0001_0000 | (32'h1 << bs[i]));
            rd(OFS_PORT_STATUS, 32'h0001_0012);
        end
        chk("set_pulse", {29'h0, set_seen}, 32'h7);
        // fixed device shows up only after hub reset
        wr(OFS_PORT_CONFIG, 32'h1);
        wr(OFS_PORT_STATUS, 32'h0001_0000);
        rhpcf_port_model_inst.set_lv(4'hB);
        rd(OFS_PORT_STATUS, 32'h0000_0013);
        rhpcf_port_model_inst.pulse(2'h2);
        rd(OFS_PORT_STATUS, 32'h0001_0013);
        wr(OFS_IRQ_MASK, 32'h0);
        @(negedge CORE_CLK);
        chk("irq", {31'h0, IRQ}, 32'h0);
        // reset in mid-run drops flags, pending events and config
        rhpcf_port_model_inst.set_lv(4'h0);
        NRST <= 1'b0;
        @(posedge CORE_CLK);
        NRST <= 1'b1;
        @(posedge CORE_CLK);
        rd(OFS_PORT_STATUS, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h0);
        rd(OFS_PORT_CONFIG, 32'h0);
        report_and_stop();
    end
endmodule // root_hub_port_change_flags_test
